// ===== core/sadc_pkg.sv
// Package of constants for the serial converter frame and power control
package sadc_pkg;
  // ==========================================================
  // Result format
  localparam int RESULT_BITS = 12;
  localparam int LEAD_ZEROS = 3;
  localparam int CODE_STEPS = 4096;
  // ==========================================================
  // Serial clock edge counts within a frame
  localparam logic [4:0] EDGE_MODE_MIN = 5'h02;
  localparam logic [4:0] EDGE_MODE_END = 5'h0A;
  localparam logic [4:0] EDGE_WORD_END = 5'h10;
  localparam logic [4:0] RISE_TRACK = 5'h0D;
  localparam logic [4:0] EDGE_MAX = 5'h1F;
  // ==========================================================
  // Reset values
  localparam logic RST_POWERED = 1'b0;
  localparam logic [11:0] RST_CODE = 12'h000;
  // ==========================================================
  // Buffer depth
  localparam int BUF_DEPTH = 2;
  // ==========================================================
  // Power state of the converter
  typedef enum logic [2:0] {
    SADC_SHUT = 3'b001,
    SADC_WAKE = 3'b010,
    SADC_NORM = 3'b100
  } sadc_mode_type;
endpackage

// ===== core/sadc_ctrl.sv
// Serial interface and power mode control of a 12-bit converter
`timescale 1ns/100ps
// Summary of operation
// - Result is 12-bit straight binary, step is reference over 4096.
// - Frame select low enters normal mode and starts a conversion.
// - Rise between falls 2 and 10 aborts, shuts down, floats output.
// - Rise before second fall leaves the mode unchanged.
// - Rise after fall 10 before 16 aborts, stays normal, floats output.
// - Output floats after sixteen clocks; host waits quiet time.
// - Shutdown holds until frame select falls again.
// - Fall in shutdown powers up; first result unusable, second valid.
// - Wake frame ending before fall 10 returns to shutdown.
// - Wake frame held past fall 10 is fully powered after 16 clocks.
// - Three zeros then twelve bits, MSB first, on falling clock edges.
// - Select fall enables the output and samples the input.
// - Output floats after fall 16 or on select rise, whichever first.
// - Hold returns to track on the thirteenth rising clock edge.
module sadc_ctrl #(
  parameter int DATA_W = 12
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic FRAME_SEL_N_IN,
  input wire logic SERIAL_CLK_IN,
  input wire logic [DATA_W-1:0] SAMPLE_CODE_IN,
  input wire logic CODE_READY_IN,
  output logic SAMPLE_REQ_OUT,
  output logic CODE_ACCEPT_OUT,
  output logic SERIAL_RESULT_OUT,
  output logic SERIAL_RESULT_OE_OUT,
  output logic TRACK_OUT,
  output logic POWERED_OUT,
  output logic SHUTDOWN_OUT,
  output logic RESULT_VALID_OUT
);

  // ==========================================================
  // Pin synchronisers
  // Three stages; a change counts once stages two and three agree
  logic [2:0] sel_sync_reg, sel_sync_next;
  logic [2:0] sck_sync_reg, sck_sync_next;
  logic sel_q_reg, sel_q_next;
  logic sck_q_reg, sck_q_next;
  // Trade-off: about four cycles of latency for glitch immunity
  // Host edges must therefore stand for at least two clocks

  // Shift the stages and let the filter follow when two and three agree
  always_comb begin
    sel_sync_next = {sel_sync_reg[1:0], FRAME_SEL_N_IN};
    sck_sync_next = {sck_sync_reg[1:0], SERIAL_CLK_IN};
    sel_q_next = sel_q_reg;
    sck_q_next = sck_q_reg;
    if (sel_sync_reg[1] == sel_sync_reg[2]) begin
      sel_q_next = sel_sync_reg[2];
    end
    if (sck_sync_reg[1] == sck_sync_reg[2]) begin
      sck_q_next = sck_sync_reg[2];
    end
  end

  // Reset to the idle levels so no false edge follows reset
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sel_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h7; // Host clock idles high
      sel_q_reg <= 1'b1;
      sck_q_reg <= 1'b1;
    end else begin
      sel_sync_reg <= sel_sync_next;
      sck_sync_reg <= sck_sync_next;
      sel_q_reg <= sel_q_next;
      sck_q_reg <= sck_q_next;
    end
  end

  // Edge events of the filtered pins
  logic sel_fall, sel_rise, sck_fall, sck_rise;
  assign sel_fall = sel_q_reg & ~sel_q_next;
  assign sel_rise = ~sel_q_reg & sel_q_next;
  assign sck_fall = sck_q_reg & ~sck_q_next;
  assign sck_rise = ~sck_q_reg & sck_q_next;

  // ==========================================================
  // Two-entry buffer between conversion core and shifter
  // A late core answer waits here instead of being dropped
  logic [DATA_W-1:0] buf_mem_reg [sadc_pkg::BUF_DEPTH];
  logic [DATA_W-1:0] buf_mem_next [sadc_pkg::BUF_DEPTH];
  logic [1:0] buf_cnt_reg, buf_cnt_next;
  // One-bit pointers suffice for two entries
  logic buf_wr_ptr_reg, buf_wr_ptr_next;
  logic buf_rd_ptr_reg, buf_rd_ptr_next;
  logic buf_push, buf_pop, buf_full, buf_empty;

  assign buf_full = (buf_cnt_reg == 2'h2);
  assign buf_empty = (buf_cnt_reg == 2'h0);
  assign CODE_ACCEPT_OUT = ~buf_full;
  assign buf_push = CODE_READY_IN & ~buf_full;

  // Push from the core and pop into the shifter may share a cycle
  always_comb begin
    buf_mem_next = buf_mem_reg;
    buf_wr_ptr_next = buf_wr_ptr_reg;
    buf_rd_ptr_next = buf_rd_ptr_reg;
    buf_cnt_next = buf_cnt_reg;
    if (buf_push) begin
      buf_mem_next[buf_wr_ptr_reg] = SAMPLE_CODE_IN;
      buf_wr_ptr_next = ~buf_wr_ptr_reg;
    end
    if (buf_pop) begin
      buf_rd_ptr_next = ~buf_rd_ptr_reg;
    end
    case ({buf_push, buf_pop})
      2'b10: buf_cnt_next = buf_cnt_reg + 2'h1;
      2'b01: buf_cnt_next = buf_cnt_reg - 2'h1;
      default: buf_cnt_next = buf_cnt_reg;
    endcase
  end

  // Entries clear to the reset code so no stale word shifts out
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      buf_mem_reg <= '{default: DATA_W'(sadc_pkg::RST_CODE)};
      buf_wr_ptr_reg <= 1'b0;
      buf_rd_ptr_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      buf_mem_reg <= buf_mem_next;
      buf_wr_ptr_reg <= buf_wr_ptr_next;
      buf_rd_ptr_reg <= buf_rd_ptr_next;
      buf_cnt_reg <= buf_cnt_next;
    end
  end

  // ==========================================================
  // Frame, mode and shift control
  localparam int SHIFT_W = DATA_W + sadc_pkg::LEAD_ZEROS + 1;
  localparam logic [4:0] EDGE_MODE_MIN = sadc_pkg::EDGE_MODE_MIN;
  localparam logic [4:0] EDGE_MODE_END = sadc_pkg::EDGE_MODE_END;
  localparam logic [4:0] EDGE_WORD_END = sadc_pkg::EDGE_WORD_END;
  localparam logic [4:0] RISE_TRACK = sadc_pkg::RISE_TRACK;
  localparam logic [4:0] EDGE_MAX = sadc_pkg::EDGE_MAX;

  sadc_pkg::sadc_mode_type mode_reg, mode_next;
  logic in_frame_reg, in_frame_next;
  logic wake_frame_reg, wake_frame_next;
  // Counters saturate so a long frame cannot wrap into a new word
  // The shifter carries a spare low bit that fills the sixteenth slot
  logic [4:0] fall_cnt_reg, fall_cnt_next;
  logic [4:0] rise_cnt_reg, rise_cnt_next;
  logic [SHIFT_W-1:0] shift_reg, shift_next;
  logic loaded_reg, loaded_next;
  logic oe_reg, oe_next;
  logic track_reg, track_next;
  logic powered_reg, powered_next;
  logic valid_reg, valid_next;
  logic req_reg, req_next;
  logic dout_reg, dout_next;

  // Never pop on a select edge: the shifter is not loaded in that cycle
  // Limitation: a code arriving after fall 1 shifts out late and loses its trailing bits
  assign buf_pop = in_frame_reg & ~loaded_reg & ~buf_empty &
                   ~sel_fall & ~sel_rise;

  // Select edges take priority over serial clock edges
  always_comb begin
    mode_next = mode_reg;
    in_frame_next = in_frame_reg;
    wake_frame_next = wake_frame_reg;
    fall_cnt_next = fall_cnt_reg;
    rise_cnt_next = rise_cnt_reg;
    shift_next = shift_reg;
    loaded_next = loaded_reg;
    oe_next = oe_reg;
    track_next = track_reg;
    powered_next = powered_reg;
    valid_next = valid_reg;
    req_next = 1'b0;
    dout_next = dout_reg;
    if (sel_fall) begin
      // Frame opens: hold the input and drive the output
      in_frame_next = 1'b1;
      fall_cnt_next = 5'h00;
      rise_cnt_next = 5'h00;
      shift_next = '0;
      loaded_next = 1'b0;
      oe_next = 1'b1;
      track_next = 1'b0;
      req_next = 1'b1;
      dout_next = 1'b0;
      // Leaving shutdown starts a power-up frame
      wake_frame_next = (mode_reg == sadc_pkg::SADC_SHUT);
      mode_next = sadc_pkg::SADC_NORM;
    end else if (sel_rise && in_frame_reg) begin
      in_frame_next = 1'b0;
      oe_next = 1'b0;
      track_next = 1'b1;
      if (fall_cnt_reg < EDGE_MODE_MIN) begin
        // Too early to be a command: noise keeps prior mode
        if (wake_frame_reg) begin
          mode_next = sadc_pkg::SADC_SHUT;
        end
      end else if (fall_cnt_reg < EDGE_MODE_END) begin
        // Falls 2 to 9 are a power-down command
        mode_next = sadc_pkg::SADC_SHUT;
        powered_next = 1'b0;
        valid_next = 1'b0;
      end else begin
        // Fall 10 onward truncates the word only
        mode_next = sadc_pkg::SADC_NORM;
      end
    end else if (in_frame_reg) begin
      if (buf_pop) begin
        // Three leading zeros ahead of the code, MSB first
        shift_next = {{sadc_pkg::LEAD_ZEROS{1'b0}},
                      buf_mem_reg[buf_rd_ptr_reg], 1'b0};
        loaded_next = 1'b1;
      end
      if (sck_rise && rise_cnt_reg != EDGE_MAX) begin
        rise_cnt_next = rise_cnt_reg + 5'h01;
        // Tracking resumes early so the next sample can settle
        if (rise_cnt_reg + 5'h01 == RISE_TRACK) begin
          track_next = 1'b1;
        end
      end
      if (sck_fall && fall_cnt_reg != EDGE_MAX) begin
        fall_cnt_next = fall_cnt_reg + 5'h01;
        // Bits shift on falling edges; receiver takes them later
        dout_next = shift_reg[SHIFT_W-1];
        shift_next = {shift_reg[SHIFT_W-2:0], 1'b0};
        // Sixteenth fall closes the word and settles validity
        if (fall_cnt_reg + 5'h01 == EDGE_WORD_END) begin
          oe_next = 1'b0;
          in_frame_next = 1'b0;
          // Any full frame while unpowered completes a power-up
          if (wake_frame_reg || !powered_reg) begin
            powered_next = 1'b1;
            valid_next = 1'b0;
          end else begin
            valid_next = powered_reg;
          end
        end
      end
    end
    // Shutdown persists until the next fall
    if (mode_reg == sadc_pkg::SADC_SHUT && !sel_fall) begin
      oe_next = 1'b0;
    end
  end

  // Frame state registers; reset leaves the converter normal, unpowered
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mode_reg <= sadc_pkg::SADC_NORM;
      in_frame_reg <= 1'b0;
      wake_frame_reg <= 1'b0;
      fall_cnt_reg <= 5'h00;
      rise_cnt_reg <= 5'h00;
      shift_reg <= '0;
      loaded_reg <= 1'b0;
      oe_reg <= 1'b0;
      track_reg <= 1'b1;
      powered_reg <= sadc_pkg::RST_POWERED;
      valid_reg <= 1'b0;
      req_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      in_frame_reg <= in_frame_next;
      wake_frame_reg <= wake_frame_next;
      fall_cnt_reg <= fall_cnt_next;
      rise_cnt_reg <= rise_cnt_next;
      shift_reg <= shift_next;
      loaded_reg <= loaded_next;
      oe_reg <= oe_next;
      track_reg <= track_next;
      powered_reg <= powered_next;
      valid_reg <= valid_next;
      req_reg <= req_next;
      dout_reg <= dout_next;
    end
  end

  // ==========================================================
  // Outputs
  // All from flip-flops except the buffer's ready and the shutdown decode of mode_reg
  assign SERIAL_RESULT_OUT = dout_reg;
  assign SERIAL_RESULT_OE_OUT = oe_reg;
  assign TRACK_OUT = track_reg;
  assign POWERED_OUT = powered_reg;
  assign SHUTDOWN_OUT = (mode_reg == sadc_pkg::SADC_SHUT);
  assign RESULT_VALID_OUT = valid_reg;
  assign SAMPLE_REQ_OUT = req_reg;

endmodule // sadc_ctrl

// ===== sim/sadc_ctrl_checker.sv
// Port-level assertions for the converter frame and power control
`timescale 1ns/100ps
module sadc_ctrl_checker (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic FRAME_SEL_N_IN,
  input wire logic SERIAL_CLK_IN,
  input wire logic SAMPLE_REQ_OUT,
  input wire logic SERIAL_RESULT_OE_OUT,
  input wire logic TRACK_OUT,
  input wire logic POWERED_OUT,
  input wire logic SHUTDOWN_OUT
);
  // ==========================================================
  // Frame start, output float, track, shutdown and power-up
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  chk_req_single: assert property (SAMPLE_REQ_OUT |=> !SAMPLE_REQ_OUT)
    else $error("request longer than one cycle");
  chk_req_cause: assert property (SAMPLE_REQ_OUT |->
    !FRAME_SEL_N_IN && !$past(FRAME_SEL_N_IN, 2))
    else $error("request without select low");
  chk_req_drive: assert property (SAMPLE_REQ_OUT |->
    SERIAL_RESULT_OE_OUT && !TRACK_OUT)
    else $error("frame start did not drive and hold");
  chk_oe_start: assert property (
    $rose(SERIAL_RESULT_OE_OUT) |-> SAMPLE_REQ_OUT)
    else $error("output enabled outside frame start");
  chk_hold_start: assert property ($fell(TRACK_OUT) |-> SAMPLE_REQ_OUT)
    else $error("hold entered outside frame start");
  // Sync delay is a few cycles, so six high cycles must float the line
  chk_oe_quiet: assert property (
    FRAME_SEL_N_IN [*6] |-> !SERIAL_RESULT_OE_OUT)
    else $error("output driven with select high");
  chk_track_edge: assert property (
    $rose(TRACK_OUT) && !FRAME_SEL_N_IN |-> SERIAL_CLK_IN)
    else $error("track resumed off a rising clock");
  chk_shut_entry: assert property ($rose(SHUTDOWN_OUT) |->
    FRAME_SEL_N_IN ##[0:1] (!POWERED_OUT && !SERIAL_RESULT_OE_OUT))
    else $error("bad shutdown entry");
  chk_power_up: assert property ($rose(POWERED_OUT) |->
    !SHUTDOWN_OUT && !FRAME_SEL_N_IN)
    else $error("powered flag set outside full frame");
  cover property ($rose(SHUTDOWN_OUT));
  cover property ($rose(POWERED_OUT));
  cover property ($fell(SERIAL_RESULT_OE_OUT) && !FRAME_SEL_N_IN);
endmodule // sadc_ctrl_checker

bind sadc_ctrl sadc_ctrl_checker u_chk (
  .CLK_IN(CLK_IN),
  .RESET_N_IN(RESET_N_IN),
  .FRAME_SEL_N_IN(FRAME_SEL_N_IN),
  .SERIAL_CLK_IN(SERIAL_CLK_IN),
  .SAMPLE_REQ_OUT(SAMPLE_REQ_OUT),
  .SERIAL_RESULT_OE_OUT(SERIAL_RESULT_OE_OUT),
  .TRACK_OUT(TRACK_OUT),
  .POWERED_OUT(POWERED_OUT),
  .SHUTDOWN_OUT(SHUTDOWN_OUT)
);

// ===== sim/sadc_host_model.sv
// Behavioural host that frames conversions and shifts in the result
`timescale 1ns/100ps
module sadc_host_model (
  input wire logic clk_in,
  input wire logic data_in,
  input wire logic oe_in,
  output logic frame_sel_n_out,
  output logic serial_clk_out
);
  // ==========================================================
  // Line view: a released line shows the inverse of its last level
  logic last_bit;
  logic wire_bit;
  always @(posedge clk_in) begin
    if (oe_in) begin
      last_bit <= data_in;
    end
  end
  assign wire_bit = oe_in ? data_in : ~last_bit;
  // Clock stands still high outside frames
  initial begin
    frame_sel_n_out = 1'b1;
    serial_clk_out = 1'b1;
  end
  // One frame of n falls padded to 20 serial clocks; falls 1..15 captured
  task automatic frame(input int n, output logic [14:0] word);
    word = 15'h0000;
    @(negedge clk_in);
    frame_sel_n_out = 1'b0;
    repeat (8) @(negedge clk_in);
    for (int i = 1; i <= n; i++) begin
      serial_clk_out = 1'b0;
      repeat (8) @(negedge clk_in);
      serial_clk_out = 1'b1;
      repeat (8) @(negedge clk_in);
      if (i <= 15) word = {word[13:0], wire_bit};
    end
    frame_sel_n_out = 1'b1;
    repeat (312 - 16 * n) @(negedge clk_in);
  endtask
endmodule // sadc_host_model

// ===== sim/test_serial_adc_frame_power_control.sv
// Self-checking bench for the converter frame and power control
`timescale 1ns/100ps
module test_serial_adc_frame_power_control;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic frame_sel_n, serial_clk, code_ready = 1'b0;
  logic [11:0] code = 12'h000;
  logic req, accept, serial_result_out, oe, track, powered, shut, valid;
  logic [14:0] word;
  int fails = 0;
  int n_tests = 0;
  // ==========================================================
  // Design and host
  sadc_ctrl #(.DATA_W(sadc_pkg::RESULT_BITS)) dut (
    .CLK_IN(clk), .RESET_N_IN(reset_n), .FRAME_SEL_N_IN(frame_sel_n),
    .SERIAL_CLK_IN(serial_clk), .SAMPLE_CODE_IN(code),
    .CODE_READY_IN(code_ready), .SAMPLE_REQ_OUT(req),
    .CODE_ACCEPT_OUT(accept), .SERIAL_RESULT_OUT(serial_result_out),
    .SERIAL_RESULT_OE_OUT(oe), .TRACK_OUT(track), .POWERED_OUT(powered),
    .SHUTDOWN_OUT(shut), .RESULT_VALID_OUT(valid));
  sadc_host_model host (.clk_in(clk), .data_in(serial_result_out), .oe_in(oe),
    .frame_sel_n_out(frame_sel_n), .serial_clk_out(serial_clk));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Ready held until the edge that takes it
  task automatic push(input logic [11:0] c);
    @(negedge clk);
    code = c;
    code_ready = 1'b1;
    check(accept, 1'b1);
    @(negedge clk);
    code_ready = 1'b0;
  endtask
  // Abort between falls 2 and 10, then noise and short wake frames
  task automatic t_shutdown();
    host.frame(5, word);
    check({shut, oe, powered}, 3'b100);
    host.frame(1, word);
    check(shut, 1'b1);
    host.frame(6, word);
    check({shut, oe}, 2'b10);
    $display("test shutdown done");
  endtask
  // Full wake frame powers up but its word is unusable
  task automatic t_wake();
    host.frame(16, word);
    check({shut, powered, valid, oe}, 4'b0100);
    $display("test wake done");
  endtask
  // Two buffered codes, back-to-back frames, valid words
  task automatic t_normal();
    push(12'hA5C);
    push(12'h3F1);
    check(accept, 1'b0);
    host.frame(16, word);
    check(word, 15'h0A5C);
    check({valid, track, oe}, 3'b110);
    host.frame(16, word);
    check(word, 15'h03F1);
    check(accept, 1'b1);
    $display("test normal done");
  endtask
  // Rise after fall 12 truncates, rise before fall 2 keeps normal mode
  task automatic t_truncate();
    push(12'hFFF);
    host.frame(12, word);
    check(word, 15'h01FF);
    check({shut, oe, powered}, 3'b001);
    host.frame(1, word);
    check({shut, oe, powered}, 3'b001);
    $display("test truncate done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Cuts a hang well past the expected run of about 15 us
  initial begin
    #60000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check({oe, track, powered, shut, valid, accept}, 6'b010001);
    host.frame(16, word);
    check({powered, valid, shut}, 3'b100);
    t_shutdown();
    t_wake();
    t_normal();
    t_truncate();
    complete_run();
  end
endmodule // test_serial_adc_frame_power_control
